/* File: src/mrm_defs.svh */
// constants for the message ram with ecc and transmit object layout
// Operation
// - two kilobyte ram stores transmit, receive and transmit event objects
// - object counts per area and payload size per queue/fifo are configurable
// - area configuration is taken only while configuration mode is active
// - transmit event objects sit lowest, reserved only if store enable is one
// - transmit queue follows, reserved only if queue enable is one
// - fifos one to thirty-one follow in ascending order
// - addresses follow configuration; per-fifo user address names next object
// - each 32-bit word carries seven sec/ded parity bits
// - with ecc on, writes store encoder parity and reads pass the decoder
// - with ecc off, writes store supplied parity; reads return data unchanged
// - decoder corrects single errors, detects doubles, strips parity
// - word 0 holds extended id in 28-11, standard id in 10-0
// - word 0 bit 29 is the extra base identifier bit
// - word 1 bits 15-9 hold sequence tag, decoded into the tx header
// - gateway mode ors esi bit with error passive, else passive state
// - word 1 holds fdf 7, brs 6, rtr 5, ide 4, dlc 3-0
// - payload starts at word 2, byte 0 low, length from payload size
`ifndef MRM_DEFS_SVH
`define MRM_DEFS_SVH

`define MRM_RAM_BYTES    2048
`define MRM_RAM_WORDS    512
`define MRM_ADDR_W       9
`define MRM_DATA_W       32
`define MRM_PAR_W        7
`define MRM_AREAS        33
`define MRM_AREA_TEF     6'h00
`define MRM_AREA_TXQ     6'h01
`define MRM_TEF_BYTES    12'h008
`define MRM_HDR_BYTES    12'h008
`define MRM_DEPTH_RST    5'h00
`define MRM_PAYLOAD_SIZE_SEL_RST   3'h0
`define MRM_T0_SID_MSB   10
`define MRM_T0_EID_LSB   11
`define MRM_T0_EID_MSB   28
`define MRM_T0_BASE_ID_EXTRA_BIT     29
`define MRM_T1_SEQ_LSB   9
`define MRM_T1_SEQ_MSB   15
`define MRM_T1_ESI       8
`define MRM_T1_FDF       7
`define MRM_T1_BRS       6
`define MRM_T1_RTR       5
`define MRM_T1_IDE       4
`define MRM_T1_DLC_MSB   3

`endif

/* File: src/mrm_pkg.sv */
// types and ecc helper functions for the message ram
package mrm_pkg;

  typedef logic [11:0] mrm_baddr_t;

  // decoded transmit object header
  typedef struct packed {
    logic        baseIdExtraBit;
    logic [17:0] extId;
    logic [10:0] stdId;
    logic [6:0]  txSequenceTag;
    logic        esi;
    logic        fdf;
    logic        brs;
    logic        rtr;
    logic        ide;
    logic [3:0]  dlc;
  } mrm_txhdr_s;

  // one ram access request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [8:0]  addr;
    logic [31:0] wdata;
  } mrm_req_s;

  // hamming position of data bit i, skipping power-of-two slots
  function automatic logic [5:0] mrmDataPos(input int i);
    int p;
    if (i < 1) p = i + 3;
    else if (i < 4) p = i + 4;
    else if (i < 11) p = i + 5;
    else if (i < 26) p = i + 6;
    else p = i + 7;
    return p[5:0];
  endfunction : mrmDataPos

  // six hamming check bits of a data word
  function automatic logic [5:0] mrmHamPar(input logic [31:0] d);
    logic [5:0] p;
    logic [5:0] pos;
    p = 6'h00;
    for (int i = 0; i < 32; i++) begin
      pos = mrmDataPos(i);
      for (int k = 0; k < 6; k++) begin
        p[k] = p[k] ^ (d[i] & pos[k]);
      end
    end
    return p;
  endfunction : mrmHamPar

endpackage : mrm_pkg

/* File: src/mrm_ecc_enc.sv */
// sec/ded encoder: six hamming bits plus overall parity
`timescale 1ns/100ps
`include "mrm_defs.svh"
module mrm_ecc_enc
  import mrm_pkg::*;
(
  input  wire logic [`MRM_DATA_W-1:0] data,
  output logic      [`MRM_PAR_W-1:0]  parity
);
  logic [5:0] ham;

  // overall bit covers data and hamming bits
  assign ham    = mrmHamPar(data);
  assign parity = {^{data, ham}, ham};
endmodule : mrm_ecc_enc

/* File: src/mrm_ecc_dec.sv */
// sec/ded decoder: corrects single errors, flags doubles
`timescale 1ns/100ps
`include "mrm_defs.svh"
module mrm_ecc_dec
  import mrm_pkg::*;
(
  input  wire logic [`MRM_DATA_W+`MRM_PAR_W-1:0] raw,
  input  wire logic                              ram_ecc_en,
  output logic      [`MRM_DATA_W-1:0]            data,
  output logic                                   secErr,
  output logic                                   dedErr
);
  logic [31:0] rawData;
  logic [5:0]  syndrome;
  logic        overall;

  assign rawData  = raw[31:0];
  assign syndrome = mrmHamPar(rawData) ^ raw[37:32];
  assign overall  = ^raw;

  // correction and classification, bypassed when ecc is off
  always_comb begin
    data   = rawData;
    secErr = 1'b0;
    dedErr = 1'b0;
    if (ram_ecc_en) begin
      secErr = overall;
      dedErr = ~overall && (syndrome != 6'h00);
      for (int i = 0; i < 32; i++) begin
        if (overall && (syndrome == mrmDataPos(i))) data[i] = ~rawData[i];
      end
    end
  end
endmodule : mrm_ecc_dec

/* File: src/mrm_message_ram.sv */
// message ram with ecc, area allocation, user addresses and tx header decode
`timescale 1ns/100ps
`include "mrm_defs.svh"
module mrm_message_ram
  import mrm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  // controller configuration
  input  wire logic                  configMode,
  input  wire logic                  storeTxEventsEn,
  input  wire logic                  txQueueEn,
  input  wire logic                  gatewayEsiMode,
  input  wire logic                  errorPassive,
  // ram ecc control
  input  wire logic                  ramEccEn,
  input  wire logic [6:0]            ramEccParity,
  // area configuration write
  input  wire logic                  cfgWr,
  input  wire logic [5:0]            cfgArea,
  input  wire logic [4:0]            cfgDepth,
  input  wire logic [2:0]            cfgPayloadSizeSel,
  output logic                       cfgRejected,
  output logic                       cfgOverflow,
  // user address query and advance
  input  wire logic [5:0]            uaSel,
  output logic [11:0]                userAddr,
  output logic [6:0]                 uaPayloadBytes,
  input  wire logic                  uaAdvance,
  input  wire logic [5:0]            uaAdvArea,
  // host access port
  input  wire mrm_req_s              hostReq,
  output logic                       hostGnt,
  output logic [31:0]                hostRdata,
  output logic                       hostRvalid,
  // protocol engine access port
  input  wire mrm_req_s              engReq,
  input  wire logic [1:0]            engHdrWord,
  output logic                       engGnt,
  output logic [31:0]                engRdata,
  output logic                       engRvalid,
  output mrm_txhdr_s                 txHdr,
  output logic                       txEsi,
  // ecc status
  input  wire logic                  eccFlagClr,
  output logic                       eccSecFlag,
  output logic                       eccDedFlag,
  output logic [8:0]                 eccErrAddr
);

  // ram storage: 512 words of data plus parity
  logic [`MRM_DATA_W+`MRM_PAR_W-1:0] mem [0:`MRM_RAM_WORDS-1];

  // area configuration tables
  logic [4:0]  areaDepth [0:`MRM_AREAS-1];
  logic [2:0]  areaPlSize [0:`MRM_AREAS-1];
  logic [4:0]  areaPtr [0:`MRM_AREAS-1];

  // access pipeline
  mrm_req_s    selReq;
  logic        selIsEng;
  logic [6:0]  encParity;
  logic [6:0]  wrParity;
  logic [38:0] rawWord;
  logic        rdP1;
  logic        rdEngP1;
  logic [1:0]  hdrP1;
  logic [8:0]  addrP1;
  logic [31:0] decData;
  logic        decSec;
  logic        decDed;
  logic        eccEnP1;

  // address arithmetic
  logic [11:0] areaBase [0:`MRM_AREAS-1];
  logic [11:0] areaSize [0:`MRM_AREAS-1];
  logic [16:0] totalBytes;  // wide enough for every area at full size

  // payload bytes for a payload size code
  function automatic logic [6:0] plBytes(input logic [2:0] sel);
    case (sel)
      3'h0: plBytes = 7'h08;
      3'h1: plBytes = 7'h0C;
      3'h2: plBytes = 7'h10;
      3'h3: plBytes = 7'h14;
      3'h4: plBytes = 7'h18;
      3'h5: plBytes = 7'h20;
      3'h6: plBytes = 7'h30;
      default: plBytes = 7'h40;
    endcase
  endfunction : plBytes

  // bytes in one object of an area
  function automatic logic [11:0] objBytes(input logic [5:0] area, input logic [2:0] sel);
    if (area == `MRM_AREA_TEF) objBytes = `MRM_TEF_BYTES;
    else objBytes = `MRM_HDR_BYTES + {5'h00, plBytes(sel)};
  endfunction : objBytes

  // area sizes, gated by the area enables
  always_comb begin
    for (int a = 0; a < `MRM_AREAS; a++) begin
      areaSize[a] = 12'((areaDepth[a] + 6'h01) * objBytes(6'(a), areaPlSize[a]));
    end
    if (!storeTxEventsEn) areaSize[0] = 12'h000;
    if (!txQueueEn) areaSize[1] = 12'h000;
  end

  // bases laid out event area, queue, then fifos in order
  always_comb begin
    areaBase[0] = 12'h000;
    for (int a = 1; a < `MRM_AREAS; a++) begin
      areaBase[a] = areaBase[a-1] + areaSize[a-1];
    end
    // running sum kept wide so an oversized setup cannot wrap below the ram size
    totalBytes = 17'h00000;
    for (int a = 0; a < `MRM_AREAS; a++) totalBytes = totalBytes + {5'h00, areaSize[a]};
  end

  // configuration tables, written only in configuration mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int a = 0; a < `MRM_AREAS; a++) begin
        areaDepth[a]  <= `MRM_DEPTH_RST;
        areaPlSize[a] <= `MRM_PAYLOAD_SIZE_SEL_RST;
      end
    end else if (cfgWr && configMode && (cfgArea < 6'(`MRM_AREAS))) begin
      areaDepth[cfgArea]  <= cfgDepth;
      areaPlSize[cfgArea] <= cfgPayloadSizeSel;
    end
  end

  // flags a configuration attempt outside configuration mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfgRejected <= 1'b0;
    else cfgRejected <= cfgWr && !configMode;
  end

  // allocation beyond the ram size
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cfgOverflow <= 1'b0;
    else cfgOverflow <= totalBytes > 17'(`MRM_RAM_BYTES);
  end

  // object pointers: cleared in configuration mode, wrap at depth
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int a = 0; a < `MRM_AREAS; a++) areaPtr[a] <= 5'h00;
    end else if (configMode) begin
      for (int a = 0; a < `MRM_AREAS; a++) areaPtr[a] <= 5'h00;
    end else if (uaAdvance && (uaAdvArea < 6'(`MRM_AREAS))) begin
      if (areaPtr[uaAdvArea] == areaDepth[uaAdvArea]) areaPtr[uaAdvArea] <= 5'h00;
      else areaPtr[uaAdvArea] <= areaPtr[uaAdvArea] + 5'h01;
    end
  end

  // user address of the next object of the selected area
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      userAddr       <= 12'h000;
      uaPayloadBytes <= 7'h00;
    end else if (uaSel < 6'(`MRM_AREAS)) begin
      userAddr <= areaBase[uaSel]
                + 12'({7'h00, areaPtr[uaSel]} * objBytes(uaSel, areaPlSize[uaSel]));
      uaPayloadBytes <= (uaSel == `MRM_AREA_TEF) ? 7'h00 : plBytes(areaPlSize[uaSel]);
    end else begin
      userAddr       <= 12'h000;
      uaPayloadBytes <= 7'h00;
    end
  end

  // arbitration: engine first, host waits
  assign engGnt   = engReq.req;
  assign hostGnt  = hostReq.req && !engReq.req;
  assign selIsEng = engReq.req;
  assign selReq   = selIsEng ? engReq : hostReq;

  mrm_ecc_enc u_enc (
    .data   (selReq.wdata),
    .parity (encParity)
  );

  // parity source follows the ecc enable
  assign wrParity = ramEccEn ? encParity : ramEccParity;

  // ram write and raw read
  always_ff @(posedge clk) begin
    if (selReq.req && selReq.we) mem[selReq.addr] <= {wrParity, selReq.wdata};
    rawWord <= mem[selReq.addr];
  end

  // read pipeline tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdP1    <= 1'b0;
      rdEngP1 <= 1'b0;
      hdrP1   <= 2'h0;
      addrP1  <= 9'h000;
      eccEnP1 <= 1'b0;
    end else begin
      rdP1    <= selReq.req && !selReq.we;
      rdEngP1 <= selIsEng;
      hdrP1   <= selIsEng ? engHdrWord : 2'h0;
      addrP1  <= selReq.addr;
      eccEnP1 <= ramEccEn;
    end
  end

  mrm_ecc_dec u_dec (
    .raw    (rawWord),
    .ram_ecc_en  (eccEnP1),
    .data   (decData),
    .secErr (decSec),
    .dedErr (decDed)
  );

  // returned read data per port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostRdata  <= 32'h0000_0000;
      hostRvalid <= 1'b0;
      engRdata   <= 32'h0000_0000;
      engRvalid  <= 1'b0;
    end else begin
      hostRvalid <= rdP1 && !rdEngP1;
      engRvalid  <= rdP1 && rdEngP1;
      if (rdP1 && !rdEngP1) hostRdata <= decData;
      if (rdP1 && rdEngP1) engRdata <= decData;
    end
  end

  // sticky ecc flags; a new event beats a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eccSecFlag <= 1'b0;
      eccDedFlag <= 1'b0;
      eccErrAddr <= 9'h000;
    end else begin
      if (rdP1 && decSec) eccSecFlag <= 1'b1;
      else if (eccFlagClr) eccSecFlag <= 1'b0;
      if (rdP1 && decDed) eccDedFlag <= 1'b1;
      else if (eccFlagClr) eccDedFlag <= 1'b0;
      if (rdP1 && (decSec || decDed)) eccErrAddr <= addrP1;
    end
  end

  // transmit header fields from engine reads of words 0 and 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txHdr <= '0;
    end else if (rdP1 && rdEngP1) begin
      if (hdrP1 == 2'h1) begin
        txHdr.baseIdExtraBit <= decData[`MRM_T0_BASE_ID_EXTRA_BIT];
        txHdr.extId <= decData[`MRM_T0_EID_MSB:`MRM_T0_EID_LSB];
        txHdr.stdId <= decData[`MRM_T0_SID_MSB:0];
      end else if (hdrP1 == 2'h2) begin
        txHdr.txSequenceTag <= decData[`MRM_T1_SEQ_MSB:`MRM_T1_SEQ_LSB];
        txHdr.esi <= decData[`MRM_T1_ESI];
        txHdr.fdf <= decData[`MRM_T1_FDF];
        txHdr.brs <= decData[`MRM_T1_BRS];
        txHdr.rtr <= decData[`MRM_T1_RTR];
        txHdr.ide <= decData[`MRM_T1_IDE];
        txHdr.dlc <= decData[`MRM_T1_DLC_MSB:0];
      end
    end
  end

  // transmitted error state indicator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) txEsi <= 1'b0;
    else if (gatewayEsiMode) txEsi <= txHdr.esi | errorPassive;
    else txEsi <= errorPassive;
  end

endmodule : mrm_message_ram

/* File: tb/mrm_message_ram_chk.sv */
// port checker for the message ram
`timescale 1ns/100ps
module mrm_message_ram_chk
  import mrm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        configMode,
  input wire logic        cfgWr,
  input wire logic        cfgRejected,
  input wire logic [5:0]  uaSel,
  input wire logic [11:0] userAddr,
  input wire logic [6:0]  uaPayloadBytes,
  input wire mrm_req_s    hostReq,
  input wire logic        hostGnt,
  input wire logic        hostRvalid,
  input wire mrm_req_s    engReq,
  input wire logic        engGnt,
  input wire logic        engRvalid,
  input wire logic        eccFlagClr,
  input wire logic        eccSecFlag,
  input wire logic        eccDedFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic badCfg;
  logic hostTake;
  logic engTake;
  logic rvAny;
  // accepted reads and refused config writes
  assign badCfg = cfgWr & ~configMode;
  assign hostTake = hostReq.req & hostGnt & ~hostReq.we;
  assign engTake = engReq.req & engGnt & ~engReq.we;
  assign rvAny = hostRvalid | engRvalid;
  cfg_reject_a: assert property (badCfg |=> cfgRejected)
    else $error("config write outside config mode not flagged");
  reject_cause_a: assert property (cfgRejected |-> $past(badCfg))
    else $error("config reject without cause");
  host_yield_a: assert property (engReq.req |-> engGnt && !hostGnt)
    else $error("host granted against engine");
  host_read_a: assert property (hostTake |-> ##[2:3] hostRvalid)
    else $error("host read not answered");
  eng_read_a: assert property (engTake |-> ##[2:3] engRvalid)
    else $error("engine read not answered");
  rvalid_cause_a: assert property (hostRvalid |-> $past(hostTake, 2) || $past(hostTake, 3))
    else $error("host read data without request");
  flag_cause_a: assert property ($rose(eccSecFlag) || $rose(eccDedFlag)
    |-> rvAny || $past(rvAny))
    else $error("ecc flag without read");
  flag_clear_a: assert property (eccFlagClr && !rvAny ##1 !rvAny
    |-> !eccSecFlag && !eccDedFlag)
    else $error("ecc flags not cleared");
  ua_range_a: assert property (uaSel > 6'h20 |=> userAddr == 12'h000)
    else $error("user address for unknown area");
  event_bytes_a: assert property (uaSel == 6'h00 |=> uaPayloadBytes == 7'h00)
    else $error("event area shows payload");
  cover property (cfgRejected);
  cover property ($rose(eccDedFlag));
  cover property (engTake);
endmodule : mrm_message_ram_chk

bind mrm_message_ram mrm_message_ram_chk u_chk (.clk, .rst, .configMode, .cfgWr, .cfgRejected,
  .uaSel, .userAddr, .uaPayloadBytes, .hostReq, .hostGnt, .hostRvalid, .engReq, .engGnt,
  .engRvalid, .eccFlagClr, .eccSecFlag, .eccDedFlag);

/* File: tb/mrm_engine_model.sv */
// protocol engine model on the engine ram port
`timescale 1ns/100ps
module mrm_engine_model
  import mrm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        engGnt,
  input  wire logic        engRvalid,
  input  wire logic [31:0] engRdata,
  output mrm_req_s         engReq,
  output logic [1:0]       engHdrWord
);
  initial begin
    engReq = '0;
    engHdrWord = 2'h0;
  end
  // one word access after idle cycles, held until granted
  task automatic access(input logic we, input logic [8:0] a, input logic [31:0] d,
                        input logic [1:0] hdr, input int idle, output logic [31:0] q);
    repeat (idle) @(negedge clk);
    @(negedge clk);
    engReq = '{1'b1, we, a, d};
    engHdrWord = hdr;
    @(posedge clk);
    while (engGnt !== 1'b1) @(posedge clk);
    @(negedge clk);
    engReq = '{1'b0, ~we, ~a, ~d}; // released lines do not keep the old value
    engHdrWord = 2'h0;
    q = 32'h0;
    if (!we) begin
      for (int i = 0; i < 8 && engRvalid !== 1'b1; i++) @(negedge clk);
      q = engRdata;
    end
  endtask : access
endmodule : mrm_engine_model

/* File: tb/test_mrm_message_ram.sv */
// self-checking bench for the message ram
`timescale 1ns/100ps
`define CHK(what, exp, got) begin nCompared++; if ((got) !== (exp)) begin badCount++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
module test_mrm_message_ram import mrm_pkg::*;;
  logic clk, rst, configMode, storeTxEventsEn, txQueueEn, gatewayEsiMode, errorPassive;
  logic ramEccEn, cfgWr, cfgRejected, cfgOverflow, uaAdvance, hostGnt, hostRvalid;
  logic engGnt, engRvalid, txEsi, eccFlagClr, eccSecFlag, eccDedFlag;
  logic [6:0]  ramEccParity, uaPayloadBytes;
  logic [5:0]  cfgArea, uaSel, uaAdvArea;
  logic [4:0]  cfgDepth;
  logic [2:0]  cfgPayloadSizeSel;
  logic [11:0] userAddr;
  logic [31:0] hostRdata, engRdata, q;
  logic [8:0]  eccErrAddr;
  logic [1:0]  engHdrWord;
  mrm_req_s    hostReq, engReq;
  mrm_txhdr_s  txHdr;
  int          badCount = 0;
  int          nCompared = 0;
  logic [11:0] addrTab [4] = '{12'h000, 12'h010, 12'h04C, 12'h06C};
  logic [6:0]  plTab [8] = '{7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
  logic [31:0] eDatTab [3] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0000};
  logic [6:0]  eParTab [3] = '{7'h00, 7'h00, 7'h01};
  logic [1:0]  eFlgTab [3] = '{2'h2, 2'h1, 2'h2};
  logic [2:0]  esiTab [3] = '{3'h5, 3'h0, 3'h3};
  localparam mrm_txhdr_s EXP_HDR = '{1'h1, 18'h2A5C3, 11'h5A6, 7'h5B, 1'h1, 1'h1, 1'h0,
                                     1'h1, 1'h0, 4'hD};
  mrm_message_ram dut (.clk, .rst, .configMode, .storeTxEventsEn, .txQueueEn, .gatewayEsiMode,
    .errorPassive, .ramEccEn, .ramEccParity, .cfgWr, .cfgArea, .cfgDepth, .cfgPayloadSizeSel,
    .cfgRejected, .cfgOverflow, .uaSel, .userAddr, .uaPayloadBytes, .uaAdvance, .uaAdvArea,
    .hostReq, .hostGnt, .hostRdata, .hostRvalid, .engReq, .engHdrWord, .engGnt, .engRdata,
    .engRvalid, .txHdr, .txEsi, .eccFlagClr, .eccSecFlag, .eccDedFlag, .eccErrAddr);
  mrm_engine_model eng (.clk, .engGnt, .engRvalid, .engRdata, .engReq, .engHdrWord);
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // verdict and end of run
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : printVerdict
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    printVerdict();
  end
  // area configuration write
  task automatic cfg(input logic [5:0] a, input logic [4:0] dep, input logic [2:0] pl);
    @(negedge clk);
    {cfgWr, cfgArea, cfgDepth, cfgPayloadSizeSel} = {1'b1, a, dep, pl};
    @(negedge clk);
    cfgWr = 1'b0;
  endtask : cfg
  // user address of one area
  task automatic uaChk(input logic [5:0] s, input logic [11:0] exp);
    @(negedge clk);
    uaSel = s;
    repeat (2) @(negedge clk);
    `CHK("user address", exp, userAddr)
  endtask : uaChk
  // one pulse on a strobe input
  task automatic pulse(ref logic sig);
    @(negedge clk);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
  endtask : pulse
  // host word access, held until granted
  task automatic hostDo(input logic we, input logic [8:0] a, input logic [31:0] d);
    @(negedge clk);
    hostReq = '{1'b1, we, a, d};
    @(posedge clk);
    while (hostGnt !== 1'b1) @(posedge clk);
    @(negedge clk);
    hostReq = '{1'b0, ~we, ~a, ~d};
    if (!we) begin
      for (int i = 0; i < 8 && hostRvalid !== 1'b1; i++) @(negedge clk);
      `CHK("host read valid", 1'b1, hostRvalid)
    end
  endtask : hostDo
  // main sequence
  initial begin
    {rst, configMode, storeTxEventsEn, txQueueEn, gatewayEsiMode, errorPassive} = 6'h20;
    {ramEccEn, ramEccParity, cfgWr, cfgArea, cfgDepth, cfgPayloadSizeSel} = '0;
    {uaSel, uaAdvance, uaAdvArea, eccFlagClr} = '0;
    hostReq = '0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("reset outputs", 7'h00,
      {cfgRejected, cfgOverflow, hostRvalid, engRvalid, eccSecFlag, eccDedFlag, txEsi})
    {configMode, storeTxEventsEn, txQueueEn} = 3'h7;
    cfg(6'h00, 5'h01, 3'h0);
    cfg(6'h01, 5'h02, 3'h1);
    cfg(6'h02, 5'h01, 3'h0);
    for (int i = 0; i < 4; i++) uaChk(i[5:0], addrTab[i]);
    storeTxEventsEn = 1'b0;
    uaChk(6'h01, 12'h000);
    uaChk(6'h02, 12'h03C);
    txQueueEn = 1'b0;
    uaChk(6'h02, 12'h000);
    {storeTxEventsEn, txQueueEn} = 2'h3;
    `CHK("no overflow", 1'b0, cfgOverflow)
    cfg(6'h02, 5'h1F, 3'h7);
    repeat (2) @(negedge clk);
    `CHK("overflow", 1'b1, cfgOverflow)
    for (int i = 0; i < 8; i++) begin
      cfg(6'h02, 5'h01, i[2:0]);
      uaChk(6'h02, 12'h04C);
      `CHK("payload bytes", plTab[i], uaPayloadBytes)
    end
    cfg(6'h02, 5'h01, 3'h0);
    configMode = 1'b0;
    uaAdvArea = 6'h02;
    pulse(uaAdvance);
    uaChk(6'h02, 12'h05C);
    pulse(uaAdvance);
    uaChk(6'h02, 12'h04C);
    cfg(6'h02, 5'h01, 3'h7);
    `CHK("config refused", 1'b1, cfgRejected)
    uaChk(6'h02, 12'h04C);
    `CHK("payload kept", 7'h08, uaPayloadBytes)
    ramEccEn = 1'b1;
    hostDo(1'b1, 9'h100, 32'hA5C3_0F69);
    hostDo(1'b0, 9'h100, 32'h0);
    `CHK("ecc round trip", 32'hA5C3_0F69, hostRdata)
    for (int i = 0; i < 3; i++) begin
      pulse(eccFlagClr);
      ramEccEn = 1'b0;
      ramEccParity = eParTab[i];
      hostDo(1'b1, 9'h120, eDatTab[i]);
      hostDo(1'b0, 9'h120, 32'h0);
      `CHK("raw read", eDatTab[i], hostRdata)
      `CHK("no flag ecc off", 2'h0, {eccSecFlag, eccDedFlag})
      ramEccEn = 1'b1;
      eng.access(1'b0, 9'h120, 32'h0, 2'h0, i, q);
      repeat (2) @(negedge clk);
      `CHK("ecc flags", eFlgTab[i], {eccSecFlag, eccDedFlag})
      `CHK("error address", 9'h120, eccErrAddr)
      if (i != 1) `CHK("corrected word", 32'h0, q)
    end
    eng.access(1'b1, 9'h040, {2'h0, 1'h1, 18'h2A5C3, 11'h5A6}, 2'h0, 0, q);
    eng.access(1'b1, 9'h041, {16'hFFFF, 7'h5B, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 4'hD}, 2'h0, 0,
      q);
    eng.access(1'b0, 9'h040, 32'h0, 2'h1, 0, q);
    eng.access(1'b0, 9'h041, 32'h0, 2'h2, 0, q);
    repeat (2) @(negedge clk);
    `CHK("tx header", EXP_HDR, txHdr)
    for (int i = 0; i < 3; i++) begin
      {gatewayEsiMode, errorPassive} = esiTab[i][2:1];
      eng.access(1'b0, 9'h041, 32'h0, 2'h2, 1, q);
      repeat (2) @(negedge clk);
      `CHK("esi", esiTab[i][0], txEsi)
    end
    printVerdict();
  end
endmodule : test_mrm_message_ram
